/* logic/pms_sequencer.sv */
// Probe maintenance sequencer: boot path, probe power and bias control.
// Discretes arrive from pins; commands are one-cycle pulses on clk_i.
`timescale 1ns/1ns
// Overview of operation
// - ROM-only maintenance biases the probe to about 10 volts.
// - Maintenance software ignores general power-control commands.
// - Trigger mask 0,3 starts maintenance without setting the discrete status.
// - Trigger mask 0,4 sets bias to 0 volts, probe stays powered.
// - Active-state command switches processor clocks to full speed.
// - Valid bulk image runs; absent or corrupt keeps ROM taking load records.
// - Downloaded software logs load records as invalid and ignores them.
// - Storing a load record other than the last marks the next bulk image invalid.
// - Maintenance software load initializes probe and status even unpowered.
// - After download, initialization powers off all hardware including probe.
// - Under maintenance software, probe power-on sequence is stretched to about 20 seconds.
// - After turn-on delay under maintenance software, bias becomes 32 volts.
// - Ordinary probe commands change bias in maintenance mode.
// - Each off-to-on maintenance transition under maintenance software restores 32 volt bias.
// - On-to-off maintenance transition removes probe power.
// - Maintenance-off leaves probe power and bias unchanged when probe biased by direct commands.
// - Sleep removes probe power and enters low-power state.
// - Maintenance may be entered by explicit commands regardless of the bit.
module pms_sequencer
  import pms_pkg::*;
#(
  parameter int unsigned ON_DELAY   = ON_DELAY_CYC,
  parameter int unsigned BULK_DELAY = BULK_LOAD_CYC,
  parameter int unsigned SAMPLE     = SAMPLE_CYC
) (
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  maint_discrete_i,
  input  wire logic  sleep_discrete_i,
  input  pms_cmd_t   cmd_i,
  output pms_probe_t probe_o,
  output pms_status_t status_o
);

  typedef struct packed {
    logic [1:0]       rst_sync;
    logic [1:0]       maint_sync;
    logic [1:0]       sleep_sync;
    pms_state_t       state;
    logic [CNT_W-1:0] cnt;
    logic             maint_on;
    logic             direct_bias;
    pms_probe_t       probe;
    pms_status_t      status;
  } pms_top_t;

  pms_top_t st_ff;
  pms_top_t nxt_st;
  logic     rst_n;
  logic     m_rise;
  logic     m_fall;
  logic     sleep_now;
  logic     is_maint_sw;
  logic     trig_on;
  logic     trig_off;

  assign rst_n       = st_ff.rst_sync[1];
  assign sleep_now   = st_ff.sleep_sync[1];
  assign is_maint_sw = (st_ff.status.sw == PMS_SW_MAINT);
  assign trig_on     = cmd_i.trigger && cmd_i.trig_group == MASK_GROUP_ZERO
                       && cmd_i.trig_mask == MASK_MAINT_ON;
  assign trig_off    = cmd_i.trigger && cmd_i.trig_group == MASK_GROUP_ZERO
                       && cmd_i.trig_mask == MASK_MAINT_OFF;

  pms_edge_sampler #(
    .PERIOD (SAMPLE)
  ) u_sampler (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .level_i (st_ff.maint_sync[1]),
    .rise_o  (m_rise),
    .fall_o  (m_fall)
  );

  always_comb begin
    nxt_st                    = st_ff;
    nxt_st.rst_sync           = {st_ff.rst_sync[0], 1'b1};
    nxt_st.maint_sync         = {st_ff.maint_sync[0], maint_discrete_i};
    nxt_st.sleep_sync         = {st_ff.sleep_sync[0], sleep_discrete_i};
    nxt_st.probe.init_pulse   = 1'b0;
    nxt_st.status.invalid_cmd = 1'b0;
    nxt_st.status.rec_store   = 1'b0;
    if (st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - CNT_W'(1);
    end
    if (cmd_i.active_state) begin
      nxt_st.status.clocks_full = 1'b1;
      nxt_st.status.low_power   = 1'b0;
      if (st_ff.status.sw == PMS_SW_ROM && st_ff.state == PMS_ST_IDLE) begin
        nxt_st.state = PMS_ST_BULK;
        nxt_st.cnt   = CNT_W'(BULK_DELAY);
      end
    end
    if (cmd_i.load_record) begin
      if (st_ff.status.sw != PMS_SW_ROM) begin
        nxt_st.status.invalid_cmd = 1'b1;
      end else if (cmd_i.record_ok) begin
        nxt_st.status.rec_store   = 1'b1;
        nxt_st.status.image_valid = cmd_i.load_last;
        if (cmd_i.load_last) begin
          nxt_st.status.sw        = PMS_SW_MAINT;
          nxt_st.state            = PMS_ST_RUN;
          nxt_st.probe.power      = 1'b0;
          nxt_st.probe.bias       = BIAS_ZERO_V;
          nxt_st.probe.init_pulse = 1'b1;
          nxt_st.status.receivers_on = 1'b0;
          nxt_st.maint_on         = 1'b0;
        end
      end else begin
        nxt_st.status.invalid_cmd = 1'b1;
      end
    end
    case (st_ff.state)
      PMS_ST_IDLE: begin
      end
      PMS_ST_BULK: begin
        if (st_ff.cnt == '0) begin
          if (st_ff.status.image_valid) begin
            nxt_st.status.sw        = PMS_SW_MAINT;
            nxt_st.probe.power      = 1'b0;
            nxt_st.probe.bias       = BIAS_ZERO_V;
            nxt_st.probe.init_pulse = 1'b1;
            nxt_st.state            = PMS_ST_RUN;
          end else begin
            nxt_st.state = PMS_ST_IDLE;
          end
        end
      end
      PMS_ST_RUN: begin
      end
      PMS_ST_PWRUP: begin
        if (st_ff.cnt == '0) begin
          nxt_st.state      = PMS_ST_BIASED;
          nxt_st.probe.bias = BIAS_MAINT_V;
        end
      end
      PMS_ST_BIASED: begin
      end
      default: nxt_st.state = PMS_ST_IDLE;
    endcase
    if (cmd_i.power_control && !is_maint_sw) begin
      nxt_st.status.receivers_on = 1'b1;
    end
    if (m_rise || cmd_i.maint_enter) begin
      nxt_st.maint_on = 1'b1;
      nxt_st.direct_bias = 1'b0;
      if (st_ff.status.sw == PMS_SW_ROM) begin
        nxt_st.probe.power = 1'b1;
        nxt_st.probe.bias  = BIAS_ROM_V;
      end else if (is_maint_sw) begin
        nxt_st.probe.power = 1'b1;
        nxt_st.probe.bias  = BIAS_ZERO_V;
        if (st_ff.state == PMS_ST_BIASED) begin
          nxt_st.probe.bias = BIAS_MAINT_V;
        end else begin
          nxt_st.state = PMS_ST_PWRUP;
          nxt_st.cnt   = CNT_W'(ON_DELAY);
        end
      end
      nxt_st.status.maint_status = m_rise;
    end
    if (trig_on) begin
      nxt_st.status.sw   = PMS_SW_SCIENCE;
      nxt_st.probe.power = 1'b1;
      nxt_st.probe.bias  = BIAS_MAINT_V;
    end
    if (trig_off) begin
      nxt_st.probe.bias = BIAS_ZERO_V;
    end
    if (cmd_i.probe_cmd && st_ff.probe.power) begin
      nxt_st.probe.bias  = cmd_i.probe_bias;
      nxt_st.direct_bias = !st_ff.maint_on;
    end
    if ((m_fall || cmd_i.maint_leave) && st_ff.maint_on && !st_ff.direct_bias) begin
      nxt_st.probe.power = 1'b0;
      nxt_st.probe.bias  = BIAS_ZERO_V;
      nxt_st.maint_on    = 1'b0;
      nxt_st.status.maint_status = 1'b0;
      if (st_ff.state == PMS_ST_PWRUP || st_ff.state == PMS_ST_BIASED) begin
        nxt_st.state = PMS_ST_RUN;
      end
    end else if (m_fall) begin
      nxt_st.status.maint_status = 1'b0;
    end
    if (sleep_now) begin
      nxt_st.probe.power  = 1'b0;
      nxt_st.probe.bias   = BIAS_ZERO_V;
      nxt_st.status.low_power   = 1'b1;
      nxt_st.status.clocks_full = 1'b0;
      nxt_st.status.receivers_on = 1'b0;
      nxt_st.maint_on     = 1'b0;
      if (st_ff.state == PMS_ST_PWRUP || st_ff.state == PMS_ST_BIASED) begin
        nxt_st.state = PMS_ST_RUN;
      end
    end
    if (cmd_i.reset_assert) begin
      nxt_st.state       = PMS_ST_IDLE;
      nxt_st.status.sw   = PMS_SW_ROM;
      nxt_st.probe.power = 1'b0;
      nxt_st.probe.bias  = BIAS_ZERO_V;
      nxt_st.maint_on    = 1'b0;
      nxt_st.cnt         = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign probe_o  = st_ff.probe;
  assign status_o = st_ff.status;

  sequence s_pwrup_start;
    st_ff.state != PMS_ST_PWRUP ##1 st_ff.state == PMS_ST_PWRUP;
  endsequence

  property p_no_recv_power;
    @(posedge clk_i) disable iff (!rst_n)
      cmd_i.power_control && is_maint_sw && !status_o.receivers_on
      && !sleep_now |=> !status_o.receivers_on;
  endproperty
  a_no_recv_power: assert property (p_no_recv_power)
    else $error("Power control acted under maintenance software");

  property p_trig_no_status;
    @(posedge clk_i) disable iff (!rst_n)
      trig_on && !m_rise && !cmd_i.maint_enter && !status_o.maint_status
      |=> !status_o.maint_status;
  endproperty
  a_trig_no_status: assert property (p_trig_no_status)
    else $error("Trigger start set maintenance status");

  property p_clocks_full;
    @(posedge clk_i) disable iff (!rst_n)
      cmd_i.active_state && !sleep_now |=> status_o.clocks_full;
  endproperty
  a_clocks_full: assert property (p_clocks_full)
    else $error("Clocks not at full speed after active command");

  property p_invalid_log;
    @(posedge clk_i) disable iff (!rst_n)
      cmd_i.load_record && status_o.sw != PMS_SW_ROM && !cmd_i.reset_assert
      |=> status_o.invalid_cmd && !status_o.rec_store;
  endproperty
  a_invalid_log: assert property (p_invalid_log)
    else $error("Load record not logged invalid");

  property p_stretch;
    @(posedge clk_i) disable iff (!rst_n)
      s_pwrup_start |-> (probe_o.bias != BIAS_MAINT_V) [*8];
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("Bias applied before turn-on delay");

  property p_sleep_off;
    @(posedge clk_i) disable iff (!rst_n)
      sleep_now |=> !probe_o.power && status_o.low_power;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("Sleep did not remove probe power");

  property p_rom_bias;
    @(posedge clk_i) disable iff (!rst_n)
      status_o.sw == PMS_SW_ROM && m_rise && !sleep_now && !cmd_i.reset_assert
      && !trig_on && !trig_off && !cmd_i.probe_cmd && !cmd_i.load_record
      && !cmd_i.maint_leave
      |=> probe_o.power && probe_o.bias == BIAS_ROM_V;
  endproperty
  a_rom_bias: assert property (p_rom_bias)
    else $error("ROM maintenance bias wrong");

  property p_fall_off;
    @(posedge clk_i) disable iff (!rst_n)
      m_fall && st_ff.maint_on && !st_ff.direct_bias |=> !probe_o.power;
  endproperty
  a_fall_off: assert property (p_fall_off)
    else $error("Probe still powered after maintenance off");

  property p_trig_off_bias;
    @(posedge clk_i) disable iff (!rst_n)
      trig_off && !cmd_i.probe_cmd && !sleep_now && !cmd_i.reset_assert && !m_fall
      && !cmd_i.maint_leave && !m_rise && !cmd_i.maint_enter && !cmd_i.load_record
      |=> probe_o.bias == BIAS_ZERO_V && $stable(probe_o.power);
  endproperty
  a_trig_off_bias: assert property (p_trig_off_bias)
    else $error("Trigger end did not zero bias with power kept");

  property p_rise_restore;
    @(posedge clk_i) disable iff (!rst_n)
      (m_rise || cmd_i.maint_enter) && is_maint_sw && st_ff.state == PMS_ST_BIASED
      && !trig_on && !trig_off && !cmd_i.probe_cmd && !sleep_now && !cmd_i.reset_assert
      && !cmd_i.load_record && !cmd_i.maint_leave
      |=> probe_o.bias == BIAS_MAINT_V;
  endproperty
  a_rise_restore: assert property (p_rise_restore)
    else $error("Maintenance entry did not restore full bias");

  property p_load_done;
    @(posedge clk_i) disable iff (!rst_n)
      cmd_i.load_record && cmd_i.record_ok && cmd_i.load_last && status_o.sw == PMS_SW_ROM
      && !m_rise && !cmd_i.maint_enter && !trig_on && !cmd_i.reset_assert
      |=> !probe_o.power && probe_o.init_pulse && status_o.sw == PMS_SW_MAINT;
  endproperty
  a_load_done: assert property (p_load_done)
    else $error("Download end did not power down and initialize");

  property p_bulk_boot;
    @(posedge clk_i) disable iff (!rst_n)
      st_ff.state == PMS_ST_BULK && st_ff.cnt == '0 && status_o.image_valid
      && !cmd_i.reset_assert && !trig_on
      |=> status_o.sw == PMS_SW_MAINT;
  endproperty
  a_bulk_boot: assert property (p_bulk_boot)
    else $error("Valid bulk image not executed");

endmodule

/* shared/pms_pkg.sv */
// Package for the probe maintenance sequencer: modes, timing and carriers.
// Assumes a single 10 MHz clock domain.
package pms_pkg;

  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned ON_DELAY_S       = 20;
  localparam int unsigned ON_DELAY_CYC     = ON_DELAY_S * CLK_HZ;
  localparam int unsigned BULK_LOAD_S      = 360;
  localparam int unsigned BULK_LOAD_CYC    = BULK_LOAD_S * CLK_HZ;
  localparam int unsigned SAMPLE_US        = 100;
  localparam int unsigned SAMPLE_CYC       = SAMPLE_US * (CLK_HZ / 1_000_000);
  localparam int          CNT_W            = 32;

  localparam logic [7:0]  BIAS_ZERO_V      = 8'h00;
  localparam logic [7:0]  BIAS_ROM_V       = 8'h0A;
  localparam logic [7:0]  BIAS_MAINT_V     = 8'h20;
  localparam logic [7:0]  MASK_MAINT_ON    = 8'h03;
  localparam logic [7:0]  MASK_MAINT_OFF   = 8'h04;
  localparam logic [7:0]  MASK_GROUP_ZERO  = 8'h00;

  typedef enum logic [1:0] {
    PMS_SW_ROM,
    PMS_SW_MAINT,
    PMS_SW_SCIENCE
  } pms_sw_t;

  typedef enum logic [2:0] {
    PMS_ST_IDLE,
    PMS_ST_BULK,
    PMS_ST_RUN,
    PMS_ST_PWRUP,
    PMS_ST_BIASED
  } pms_state_t;

  // One command from the spacecraft bus interface, pulsed for one cycle
  typedef struct packed {
    logic       reset_release;
    logic       reset_assert;
    logic       active_state;
    logic       power_control;
    logic       trigger;
    logic [7:0] trig_group;
    logic [7:0] trig_mask;
    logic       load_record;
    logic       load_last;
    logic       record_ok;
    logic       probe_cmd;
    logic [7:0] probe_bias;
    logic       maint_enter;
    logic       maint_leave;
  } pms_cmd_t;

  // Probe electronics outputs
  typedef struct packed {
    logic       power;
    logic [7:0] bias;
    logic       init_pulse;
  } pms_probe_t;

  // Status toward housekeeping
  typedef struct packed {
    pms_sw_t    sw;
    logic       clocks_full;
    logic       low_power;
    logic       maint_status;
    logic       receivers_on;
    logic       image_valid;
    logic       invalid_cmd;
    logic       rec_store;
  } pms_status_t;

endpackage

/* logic/pms_edge_sampler.sv */
// Periodic sampler of the maintenance discrete with change detection.
// Input is synchronous to clk_i; sampling period is a parameter.
`timescale 1ns/1ns
module pms_edge_sampler
  import pms_pkg::*;
#(
  parameter int unsigned PERIOD = SAMPLE_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             last;
    logic             rise;
    logic             fall;
  } pms_samp_t;

  pms_samp_t st_ff;
  pms_samp_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.rise = 1'b0;
    nxt_st.fall = 1'b0;
    if (st_ff.cnt >= CNT_W'(PERIOD - 1)) begin
      nxt_st.cnt  = '0;
      nxt_st.last = level_i;
      nxt_st.rise = level_i & ~st_ff.last;
      nxt_st.fall = ~level_i & st_ff.last;
    end else begin
      nxt_st.cnt = st_ff.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rise_o = st_ff.rise;
  assign fall_o = st_ff.fall;

  property p_steady_no_edge;
    @(posedge clk_i) disable iff (!rst_n_i)
      $stable(st_ff.last) |-> !rise_o && !fall_o;
  endproperty
  a_steady_no_edge: assert property (p_steady_no_edge)
    else $error("Edge reported on steady level");

endmodule

/* verification/pms_bus_master.sv */
// Model of the spacecraft bus interface: one-cycle command pulses.
// Assumes the sequencer takes each strobe at the following rising edge of clk_i.
`timescale 1ns/1ns
module pms_bus_master
  import pms_pkg::*;
(
  input  wire logic clk_i,
  output pms_cmd_t  cmd_o
);
  localparam int MAX_COPIES = 4;

  initial cmd_o = '0;

  // Pulse one command for a single cycle
  task automatic send(input pms_cmd_t c);
    @(posedge clk_i);
    cmd_o <= c;
    @(posedge clk_i);
    cmd_o <= '0;
  endtask

  // Release, reset, release, then active state
  task automatic boot();
    pms_cmd_t c;
    c = '0;
    c.reset_release = 1'b1;
    send(c);
    c = '0;
    c.reset_assert = 1'b1;
    send(c);
    c = '0;
    c.reset_release = 1'b1;
    send(c);
    c = '0;
    c.active_state = 1'b1;
    send(c);
  endtask

  // One load record of an image copy
  task automatic record(input logic last, input logic ok);
    pms_cmd_t c;
    c = '0;
    c.load_record = 1'b1;
    c.load_last = last;
    c.record_ok = ok;
    send(c);
  endtask
endmodule

/* verification/test_probe_maintenance_sequencer.sv */
// Self-checking bench for the probe maintenance sequencer.
// Assumes shortened delays and the bus master model driving cmd_i.
`timescale 1ns/1ns
module test_probe_maintenance_sequencer
  import pms_pkg::*;
;
  localparam int unsigned ON_D   = 20;
  localparam int unsigned BULK_D = 30;

  logic        clk_i          = 1'b0;
  logic        rst_n_i        = 1'b0;
  logic        maint_discrete = 1'b0;
  logic        sleep_discrete = 1'b0;
  pms_cmd_t    cmd;
  pms_probe_t  probe;
  pms_status_t status;
  int          error_cnt      = 0;
  int          comparisons    = 0;
  integer      seed           = 32'h9B06823C;
  logic [7:0]  rnd_bias;
  int          n_rec;

  always #50 clk_i = ~clk_i;

  pms_bus_master u_far (.clk_i(clk_i), .cmd_o(cmd));

  pms_sequencer #(.ON_DELAY(ON_D), .BULK_DELAY(BULK_D), .SAMPLE(2)) DUT (
    .clk_i           (clk_i),
    .rst_n_i         (rst_n_i),
    .maint_discrete_i(maint_discrete),
    .sleep_discrete_i(sleep_discrete),
    .cmd_i           (cmd),
    .probe_o         (probe),
    .status_o        (status)
  );

  task automatic results();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      $display("mismatch %s expected %b seen %b", n, e, g);
      error_cnt++;
    end
  endtask

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask

  task automatic chk_sw(input string n, input pms_sw_t e, input pms_sw_t g);
    comparisons++;
    if (g !== e) begin
      $display("mismatch %s expected %0d seen %0d", n, e, g);
      error_cnt++;
    end
  endtask

  // Probe power or bias, by selector
  function automatic logic [7:0] pick(input int sel);
    pick = (sel == 0) ? {7'h00, probe.power} : probe.bias;
  endfunction

  // Bias expected right after a maintenance rise
  function automatic logic [7:0] rise_bias(input pms_sw_t sw);
    rise_bias = (sw == PMS_SW_ROM) ? BIAS_ROM_V : BIAS_ZERO_V;
  endfunction

  function automatic pms_cmd_t cmd_of(input int k, input logic [7:0] v);
    cmd_of = '0;
    case (k)
      0: cmd_of.power_control = 1'b1;
      1: begin
        cmd_of.trigger = 1'b1;
        cmd_of.trig_group = MASK_GROUP_ZERO;
        cmd_of.trig_mask = v;
      end
      2: begin
        cmd_of.probe_cmd = 1'b1;
        cmd_of.probe_bias = v;
      end
      3: cmd_of.maint_enter = 1'b1;
      default: cmd_of.maint_leave = 1'b1;
    endcase
  endfunction

  task automatic wait_for(input int sel, input logic [7:0] v);
    int i;
    #1;
    for (i = 0; i < 40 && pick(sel) !== v; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (pick(sel) !== v) begin
      $display("mismatch wait %0d expected %h seen %h", sel, v, pick(sel));
      error_cnt++;
      results();
    end
  endtask

  initial begin
    rnd_bias = 8'h00;
    n_rec = 0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    u_far.boot();
    #1;
    chk_bit("clocks full", 1'b1, status.clocks_full);
    repeat (BULK_D + 5) @(posedge clk_i);
    #1;
    chk_sw("sw no image", PMS_SW_ROM, status.sw);
    chk_bit("image valid", 1'b0, status.image_valid);
    @(posedge clk_i);
    maint_discrete <= 1'b1;
    wait_for(0, 8'h01);
    chk_byte("rom bias", rise_bias(PMS_SW_ROM), probe.bias);
    u_far.record(1'b1, 1'b0);
    #1;
    chk_bit("corrupt record", 1'b1, status.invalid_cmd);
    chk_sw("sw corrupt", PMS_SW_ROM, status.sw);
    n_rec = 2 + (($random(seed) & 32'h7FFFFFFF) % (u_far.MAX_COPIES - 1));
    for (int j = 1; j < n_rec; j++) begin
      u_far.record(1'b0, 1'b1);
      #1;
      chk_bit("record stored", 1'b1, status.rec_store);
      chk_bit("image mid load", 1'b0, status.image_valid);
    end
    u_far.record(1'b1, 1'b1);
    #1;
    chk_bit("image valid end", 1'b1, status.image_valid);
    chk_sw("sw loaded", PMS_SW_MAINT, status.sw);
    chk_bit("init pulse", 1'b1, probe.init_pulse);
    chk_bit("power after load", 1'b0, probe.power);
    repeat (10) @(posedge clk_i);
    #1;
    chk_bit("steady bit", 1'b0, probe.power);
    @(posedge clk_i);
    maint_discrete <= 1'b0;
    repeat (10) @(posedge clk_i);
    maint_discrete <= 1'b1;
    wait_for(0, 8'h01);
    chk_bit("maint status", 1'b1, status.maint_status);
    chk_byte("bias at power on", rise_bias(PMS_SW_MAINT), probe.bias);
    repeat (ON_D / 2) @(posedge clk_i);
    #1;
    chk_byte("bias mid delay", BIAS_ZERO_V, probe.bias);
    wait_for(1, BIAS_MAINT_V);
    u_far.record(1'b0, 1'b1);
    #1;
    chk_bit("record refused", 1'b1, status.invalid_cmd);
    chk_sw("sw kept", PMS_SW_MAINT, status.sw);
    u_far.send(cmd_of(0, 8'h00));
    #1;
    chk_bit("receivers", 1'b0, status.receivers_on);
    rnd_bias = 8'(($random(seed) & 32'h7F) | 32'h40);
    u_far.send(cmd_of(2, rnd_bias));
    #1;
    chk_byte("probe cmd bias", rnd_bias, probe.bias);
    u_far.send(cmd_of(3, 8'h00));
    #1;
    chk_byte("enter bias", BIAS_MAINT_V, probe.bias);
    @(posedge clk_i);
    maint_discrete <= 1'b0;
    wait_for(0, 8'h00);
    chk_byte("bias off", BIAS_ZERO_V, probe.bias);
    u_far.send(cmd_of(1, MASK_MAINT_ON));
    #1;
    chk_sw("sw trigger", PMS_SW_SCIENCE, status.sw);
    chk_bit("trigger power", 1'b1, probe.power);
    chk_byte("trigger bias", BIAS_MAINT_V, probe.bias);
    chk_bit("trigger status", 1'b0, status.maint_status);
    u_far.send(cmd_of(1, MASK_MAINT_OFF));
    #1;
    chk_byte("end bias", BIAS_ZERO_V, probe.bias);
    chk_bit("end power", 1'b1, probe.power);
    u_far.send(cmd_of(0, 8'h00));
    #1;
    chk_bit("receivers science", 1'b1, status.receivers_on);
    rnd_bias = 8'(($random(seed) & 32'h7F) | 32'h40);
    u_far.send(cmd_of(2, rnd_bias));
    u_far.send(cmd_of(4, 8'h00));
    #1;
    chk_bit("leave power", 1'b1, probe.power);
    chk_byte("leave bias", rnd_bias, probe.bias);
    @(posedge clk_i);
    sleep_discrete <= 1'b1;
    wait_for(0, 8'h00);
    chk_bit("low power", 1'b1, status.low_power);
    chk_bit("sleep receivers", 1'b0, status.receivers_on);
    @(posedge clk_i);
    sleep_discrete <= 1'b0;
    repeat (5) @(posedge clk_i);
    u_far.boot();
    repeat (BULK_D + 5) @(posedge clk_i);
    #1;
    chk_bit("clocks full again", 1'b1, status.clocks_full);
    chk_sw("sw from bulk", PMS_SW_MAINT, status.sw);
    chk_bit("bulk power", 1'b0, probe.power);
    results();
  end
endmodule
